/* rtl/pic_command.sv */
// Command word decoding and priority logic of the eight-input interrupt controller.
//
// Overview of operation
// - First init word clears in-service and mask registers, unmasking all inputs.
// - First init word leaves special mask mode and selects request register reads.
// - First init word turns off rotation on automatic end of interrupt.
// - After init, fully nested priority with input zero highest, seven lowest.
// - Init clears edge latches; edge mode then needs a fresh rising edge.
// - Interval bit picks 4-byte spacing when set, 8-byte when clear, 8-bit style.
// - Trigger bit picks level-sensitive inputs when set, edge-sensitive when clear.
// - Call address: request number at bits 2-4 or 3-5, lower bits zero, rest programmed.
// - 16-bit style vector: upper five bits programmed, lower three the level.
// - Master cascade word marks which inputs carry a slave.
// - Slave cascade word low three bits hold its identity.
// - Processor style bit picks 16-bit vectoring when one, call style when zero.
// - Auto-end bit clears in-service at acknowledge in the master role only; else explicit end needed.
// - Role bit makes the controller master when one, slave when zero.
// - Nesting bit selects special fully nested mode; master only by software.
// - Mask bit one blocks its input, zero enables it; reads return the same.
// - Three-bit code decodes rotation, end, no-op and priority set commands.
// - Level field names one level, used only when select-level bit is one.
// - Special mask bit takes effect only when its write enable bit is one.
// - Poll bit issues a poll, taking precedence over read-register in same word.
// - Register select picks in-service or request register only with read bit set.
// - Master words sit at offsets zero and one, slave at two and three.
`timescale 1ns/100ps
`default_nettype none
module pic_command
  import pic_pkg::*;
#(
  parameter int NUM_INPUTS = 8
)(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire pic_bus_type BUS,
  input wire logic [NUM_INPUTS-1:0] REQ,
  input wire pic_ack_type ACK,
  output logic [7:0] RDATA,
  output logic INT_OUT,
  output logic [2:0] INT_LEVEL,
  output logic [15:0] VECTOR,
  output logic MASTER_ROLE,
  output logic [7:0] CASCADE_WORD
);

  pic_state_type state_q;
  logic trigger_level_q;
  logic interval_four_q;
  logic [2:0] call_low_q;
  logic [7:0] vector_base_q;
  logic special_nesting_q;
  logic master_q;
  logic auto_end_q;
  logic style_16_q;
  logic [7:0] mask_q;
  logic [7:0] in_service_q;
  logic [7:0] request_q;
  logic [7:0] edge_arm_q;
  logic special_mask_q;
  logic auto_rotate_q;
  logic read_in_service_q;
  logic poll_pending_q;
  logic [2:0] lowest_q;
  logic [7:0] rdata_q;
  logic int_q;
  logic [2:0] int_level_q;
  logic [15:0] vector_q;
  logic [7:0] cascade_q;

  logic init_start;
  logic oper_low;
  logic oper_high;
  logic [2:0] cmd_code;
  logic [7:0] eligible;
  logic found;
  logic [2:0] best;
  logic [2:0] top_service;
  logic service_found;

  // Rotates a level so that the highest current priority becomes slot zero.
  function automatic logic [2:0] rank(input logic [2:0] level, input logic [2:0] lowest);
    rank = 3'(level - lowest - 3'h1);
  endfunction

  assign init_start = BUS.wr && BUS.addr == ADDR_LOW && BUS.data[INIT_ONE_MARK_BIT];
  assign oper_low = BUS.wr && BUS.addr == ADDR_LOW && !BUS.data[INIT_ONE_MARK_BIT];
  assign oper_high = BUS.wr && BUS.addr == ADDR_HIGH && state_q == ST_OPER;
  assign cmd_code = BUS.data[CODE_LSB +: 3];

  // Pick the highest-priority unmasked request and the highest in-service level.
  always_comb
  begin
    found = 1'b0;
    best = 3'h0;
    service_found = 1'b0;
    top_service = 3'h0;
    eligible = request_q & ~mask_q;
    for (int k = 7; k >= 0; k--)
    begin
      // Walk from lowest priority slot to highest so the last hit wins.
      if (in_service_q[3'(lowest_q + 3'(k) + 3'h1)])
      begin
        service_found = 1'b1;
        top_service = 3'(lowest_q + 3'(k) + 3'h1);
      end
      if (eligible[3'(lowest_q + 3'(k) + 3'h1)])
      begin
        found = 1'b1;
        best = 3'(lowest_q + 3'(k) + 3'h1);
      end
    end
  end

  // Initialization sequence; the cascade word is skipped by no mode here.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      state_q <= ST_OPER;
    else if (init_start)
      state_q <= ST_VECTOR;
    else if (BUS.wr && BUS.addr == ADDR_HIGH)
    begin
      case (state_q)
        ST_VECTOR: state_q <= ST_CASCADE;
        ST_CASCADE: state_q <= ST_MODE;
        ST_MODE: state_q <= ST_OPER;
        ST_OPER: state_q <= ST_OPER;
        default: state_q <= ST_OPER;
      endcase
    end
  end

  // Initialization word fields.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      trigger_level_q <= 1'b0;
      interval_four_q <= 1'b0;
      call_low_q <= 3'h0;
      vector_base_q <= CLEAR_BYTE;
      cascade_q <= CLEAR_BYTE;
      special_nesting_q <= 1'b0;
      master_q <= 1'b0;
      auto_end_q <= 1'b0;
      style_16_q <= 1'b0;
    end
    else if (init_start)
    begin
      trigger_level_q <= BUS.data[TRIGGER_SELECT_BIT];
      interval_four_q <= BUS.data[VECTOR_INTERVAL_BIT];
      call_low_q <= BUS.data[7:5];
    end
    else if (BUS.wr && BUS.addr == ADDR_HIGH)
    begin
      if (state_q == ST_VECTOR)
        vector_base_q <= BUS.data;
      if (state_q == ST_CASCADE)
        cascade_q <= BUS.data;
      if (state_q == ST_MODE)
      begin
        special_nesting_q <= BUS.data[SPECIAL_NESTING_BIT];
        master_q <= BUS.data[ROLE_BIT];
        auto_end_q <= BUS.data[AUTO_END_BIT];
        style_16_q <= BUS.data[PROCESSOR_STYLE_BIT];
      end
    end
  end

  // Mask register: a one blocks its input.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      mask_q <= MASK_RESET;
    else if (init_start)
      mask_q <= MASK_RESET;
    else if (oper_high)
      mask_q <= BUS.data;
  end

  // Operational modes from the third command word and the end command code.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      special_mask_q <= 1'b0;
      read_in_service_q <= 1'b0;
      poll_pending_q <= 1'b0;
      auto_rotate_q <= 1'b0;
      lowest_q <= LOWEST_RESET;
    end
    else if (init_start)
    begin
      special_mask_q <= 1'b0;
      read_in_service_q <= 1'b0;
      poll_pending_q <= 1'b0;
      auto_rotate_q <= 1'b0;
      lowest_q <= LOWEST_RESET;
    end
    else
    begin
      if (BUS.rd)
        poll_pending_q <= 1'b0;
      if (oper_low && BUS.data[COMMAND_MARK_BIT])
      begin
        if (BUS.data[SPECIAL_MASK_WRITE_BIT])
          special_mask_q <= BUS.data[SPECIAL_MASK_SET_BIT];
        if (BUS.data[POLL_BIT])
          poll_pending_q <= 1'b1;
        else if (BUS.data[READ_REQUEST_BIT])
          read_in_service_q <= BUS.data[READ_SELECT_BIT];
      end
      else if (oper_low)
      begin
        case (pic_cmd_type'(cmd_code))
          CMD_AUTO_ROT_OFF: auto_rotate_q <= 1'b0;
          CMD_AUTO_ROT_ON: auto_rotate_q <= 1'b1;
          CMD_NONSPEC_ROT: if (service_found) lowest_q <= top_service;
          CMD_SET_LOWEST: lowest_q <= BUS.data[2:0];
          CMD_SPEC_ROT: lowest_q <= BUS.data[2:0];
          default: lowest_q <= lowest_q;
        endcase
      end
      else if (ACK.ack && auto_end_q && master_q && auto_rotate_q)
        lowest_q <= ACK.level;
    end
  end

  // In-service register: set at acknowledge unless auto-end in the master role, cleared by end commands.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      in_service_q <= CLEAR_BYTE;
    else if (init_start)
      in_service_q <= CLEAR_BYTE;
    else
    begin
      if (oper_low && !BUS.data[COMMAND_MARK_BIT] && BUS.data[CODE_LSB])
      begin
        if (BUS.data[CODE_LSB+1])
          in_service_q[BUS.data[2:0]] <= 1'b0;
        else if (service_found)
          in_service_q[top_service] <= 1'b0;
      end
      // An acknowledge in the same cycle as an end command is never lost.
      if (ACK.ack && !(auto_end_q && master_q))
        in_service_q[ACK.level] <= 1'b1;
    end
  end

  // Request latch; edge mode needs a low level before the next rise.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      request_q <= CLEAR_BYTE;
      edge_arm_q <= CLEAR_BYTE;
    end
    else if (init_start)
    begin
      request_q <= CLEAR_BYTE;
      edge_arm_q <= CLEAR_BYTE;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        edge_arm_q[i] <= !REQ[i];
        if (trigger_level_q)
          request_q[i] <= REQ[i];
        else if (REQ[i] && edge_arm_q[i])
          request_q[i] <= 1'b1;
        else if (!REQ[i] || (ACK.ack && ACK.level == 3'(i)))
          request_q[i] <= 1'b0;
      end
    end
  end

  // Interrupt output, vector and read data all registered.
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      int_q <= 1'b0;
      int_level_q <= 3'h0;
      vector_q <= 16'h0000;
      rdata_q <= CLEAR_BYTE;
    end
    else
    begin
      // Special nesting lets an equal level through; special mask ignores service.
      int_q <= found && (special_mask_q || !service_found ||
               rank(best, lowest_q) < rank(top_service, lowest_q) ||
               (special_nesting_q && best == top_service));
      int_level_q <= best;
      if (style_16_q)
        vector_q <= {8'h00, vector_base_q[7:3], best};
      else if (interval_four_q)
        vector_q <= {vector_base_q, call_low_q, best, 2'b00};
      else
        vector_q <= {vector_base_q, call_low_q[2:1], best, 3'b000};
      if (poll_pending_q)
        rdata_q <= {found, 4'h0, best};
      else if (BUS.addr == ADDR_HIGH)
        rdata_q <= mask_q;
      else
        rdata_q <= read_in_service_q ? in_service_q : request_q;
    end
  end

  assign RDATA = rdata_q;
  assign INT_OUT = int_q;
  assign INT_LEVEL = int_level_q;
  assign VECTOR = vector_q;
  assign MASTER_ROLE = master_q;
  assign CASCADE_WORD = cascade_q;

  // Init word must clear mask and service one cycle later.
  a_init_clears: assert property (@(posedge MCLK) disable iff (!RESETN)
    init_start |=> mask_q == MASK_RESET && in_service_q == CLEAR_BYTE)
    else $error("init did not clear mask and service");
  a_init_sequence: assert property (@(posedge MCLK) disable iff (!RESETN)
    init_start |=> state_q == ST_VECTOR && lowest_q == LOWEST_RESET)
    else $error("init sequence not started");
  a_mask_write: assert property (@(posedge MCLK) disable iff (!RESETN)
    oper_high |=> mask_q == $past(BUS.data))
    else $error("mask write lost");
  a_mask_blocks: assert property (@(posedge MCLK) disable iff (!RESETN)
    found |-> !mask_q[best])
    else $error("masked input selected");
  a_special_mask_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
    (oper_low && BUS.data[COMMAND_MARK_BIT] && !BUS.data[SPECIAL_MASK_WRITE_BIT])
    |=> $stable(special_mask_q))
    else $error("special mask changed without enable");
  a_vector_style: assert property (@(posedge MCLK) disable iff (!RESETN)
    style_16_q |=> VECTOR[15:8] == 8'h00)
    else $error("16-bit vector upper byte not zero");
  a_edge_fresh: assert property (@(posedge MCLK) disable iff (!RESETN)
    (init_start ##1 !trigger_level_q) |=> request_q == CLEAR_BYTE)
    else $error("edge request without fresh transition");
  a_poll_first: assert property (@(posedge MCLK) disable iff (!RESETN)
    (oper_low && BUS.data[COMMAND_MARK_BIT] && BUS.data[POLL_BIT])
    |=> poll_pending_q && $stable(read_in_service_q))
    else $error("poll did not override read select");

endmodule
`default_nettype wire

/* rtl/pic_pkg.sv */
// Package for the priority interrupt command logic: field positions, codes and reset values.
package pic_pkg;

  // Register address bit values that separate the word groups.
  localparam logic ADDR_LOW = 1'b0;
  localparam logic ADDR_HIGH = 1'b1;
  // Byte offsets of the two controllers from the board base.
  localparam logic [1:0] MASTER_OFFSET = 2'h0;
  localparam logic [1:0] SLAVE_OFFSET = 2'h2;

  // Field positions in the first initialization word.
  localparam int INIT_ONE_MARK_BIT = 4;
  localparam int TRIGGER_SELECT_BIT = 3;
  localparam int VECTOR_INTERVAL_BIT = 2;
  // Field positions in the mode word.
  localparam int SPECIAL_NESTING_BIT = 4;
  localparam int ROLE_BIT = 2;
  localparam int AUTO_END_BIT = 1;
  localparam int PROCESSOR_STYLE_BIT = 0;
  // Field positions in operational words.
  localparam int COMMAND_MARK_BIT = 3;
  localparam int SPECIAL_MASK_WRITE_BIT = 6;
  localparam int SPECIAL_MASK_SET_BIT = 5;
  localparam int POLL_BIT = 2;
  localparam int READ_REQUEST_BIT = 1;
  localparam int READ_SELECT_BIT = 0;
  localparam int CODE_LSB = 5;

  // Reset values.
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CLEAR_BYTE = 8'h00;
  localparam logic [2:0] LOWEST_RESET = 3'h7;

  // Decoded end and rotation commands.
  typedef enum logic [2:0] {
    CMD_AUTO_ROT_OFF = 3'h0,
    CMD_NONSPEC_END = 3'h1,
    CMD_NOP = 3'h2,
    CMD_SPEC_END = 3'h3,
    CMD_AUTO_ROT_ON = 3'h4,
    CMD_NONSPEC_ROT = 3'h5,
    CMD_SET_LOWEST = 3'h6,
    CMD_SPEC_ROT = 3'h7
  } pic_cmd_type;

  // Initialization sequence states, one-hot.
  typedef enum logic [3:0] {
    ST_OPER = 4'b0001,
    ST_VECTOR = 4'b0010,
    ST_CASCADE = 4'b0100,
    ST_MODE = 4'b1000
  } pic_state_type;

  // Host register access carried as one group.
  typedef struct packed {
    logic wr;
    logic rd;
    logic addr;
    logic [7:0] data;
  } pic_bus_type;

  // Interrupt acknowledge carried as one group.
  typedef struct packed {
    logic ack;
    logic [2:0] level;
  } pic_ack_type;

endpackage

/* verification/pic_host.sv */
// Host processor model that writes and reads command words on the register bus.
`timescale 1ns/100ps
`default_nettype none
module pic_host
  import pic_pkg::*;
(
  input wire logic MCLK,
  input wire logic [7:0] RDATA,
  output var pic_bus_type BUS
);
  // The bus starts idle with no strobe and with address and data driven to zero.
  initial
  begin
    BUS = '0;
  end

  // One write cycle; released data shows the inverse so stale values never match.
  task automatic write_word(input logic [1:0] offset, input logic [7:0] data);
    @(posedge MCLK);
    BUS.wr <= 1'b1;
    BUS.addr <= offset[0];
    BUS.data <= data;
    @(posedge MCLK);
    BUS.wr <= 1'b0;
    BUS.data <= ~data;
  endtask

  // Read strobe with its address; the answer is registered at the strobe edge.
  // It is taken right after that edge, since a poll answer stands for one cycle only.
  task automatic read_word(input logic [1:0] offset, output logic [7:0] data);
    @(posedge MCLK);
    BUS.rd <= 1'b1;
    BUS.addr <= offset[0];
    @(posedge MCLK);
    BUS.rd <= 1'b0;
    #1;
    data = RDATA;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the interrupt command logic.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pic_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  pic_bus_type bus;
  logic [7:0] req = 8'h00;
  pic_ack_type ack = '0;
  logic [7:0] rdata;
  logic int_out;
  logic [2:0] int_level;
  logic [15:0] vector;
  logic master_role;
  logic [7:0] cascade_word;
  logic [7:0] rd_val;
  logic [1:0] ctl_base = MASTER_OFFSET;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  // Free-running clock at 125 MHz.
  always #4 mclk = ~mclk;

  pic_command dut (
    .MCLK(mclk),
    .RESETN(resetn),
    .BUS(bus),
    .REQ(req),
    .ACK(ack),
    .RDATA(rdata),
    .INT_OUT(int_out),
    .INT_LEVEL(int_level),
    .VECTOR(vector),
    .MASTER_ROLE(master_role),
    .CASCADE_WORD(cascade_word)
  );

  pic_host host (
    .MCLK(mclk),
    .RDATA(rdata),
    .BUS(bus)
  );

  // Compare one observed value against its expected value.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Let a few edges pass and sample after their updates have landed.
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Full initialization, always all four words in order.
  task automatic init(input logic [7:0] w1, w2, w3, w4);
    host.write_word(ctl_base, w1);
    host.write_word(ctl_base + 2'h1, w2);
    host.write_word(ctl_base + 2'h1, w3);
    host.write_word(ctl_base + 2'h1, w4);
    wait_n(2);
  endtask

  // Change the request inputs on a rising edge.
  task automatic set_req(input logic [7:0] val);
    @(posedge mclk);
    req <= val;
  endtask

  // One-cycle acknowledge of a level.
  task automatic pulse_ack(input logic [2:0] lvl);
    @(posedge mclk);
    ack <= '{1'b1, lvl};
    @(posedge mclk);
    ack <= '0;
    wait_n(2);
  endtask

  // Write a command at the low address and read the selected register back.
  task automatic cmd_read(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    host.write_word(ctl_base, cmd);
    host.read_word(ctl_base, rd_val);
    check(what, {8'h00, rd_val}, {8'h00, exp});
  endtask

  // Closing report and verdict.
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  // Main sequence of scenarios.
  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    wait_n(1);
    // Level trigger, 4-byte spacing, master without auto end.
    init(8'hBD, 8'h12, 8'h02, 8'h0C);
    check("cascade", {8'h00, cascade_word}, 16'h0002);
    check("role", {15'h0000, master_role}, 16'h0001);
    host.write_word(ctl_base + 2'h1, 8'hA5);
    host.read_word(ctl_base + 2'h1, rd_val);
    check("mask", {8'h00, rd_val}, 16'h00A5);
    // A new sequence must unmask everything again.
    init(8'hBD, 8'h12, 8'h02, 8'h0C);
    host.read_word(ctl_base + 2'h1, rd_val);
    check("mask_init", {8'h00, rd_val}, 16'h0000);
    set_req(8'h08);
    wait_n(4);
    check("int", {15'h0000, int_out}, 16'h0001);
    check("vec4", vector, 16'h12AC);
    set_req(8'h0A);
    wait_n(4);
    check("level_hi", {13'h0000, int_level}, 16'h0001);
    host.write_word(ctl_base + 2'h1, 8'h02);
    wait_n(4);
    check("level_mask", {13'h0000, int_level}, 16'h0003);
    // Level zero made lowest puts input three ahead of input zero.
    host.write_word(ctl_base + 2'h1, 8'h00);
    host.write_word(ctl_base, 8'hC0);
    set_req(8'h09);
    wait_n(4);
    check("level_rot", {13'h0000, int_level}, 16'h0003);
    // 8-byte spacing drops programmed bit five.
    init(8'hB9, 8'h12, 8'h02, 8'h0C);
    set_req(8'h08);
    wait_n(4);
    check("vec8", vector, 16'h1298);
    init(8'hBD, 8'hCF, 8'h02, 8'h0D);
    check("vec16", vector, 16'h00CB);
    // In-service handling with explicit end commands.
    init(8'hBD, 8'h12, 8'h02, 8'h0C);
    set_req(8'h02);
    wait_n(4);
    pulse_ack(3'h1);
    cmd_read(8'h0B, 8'h02, "isr_ack");
    // A lower request waits behind level one until special mask mode is on.
    set_req(8'h08);
    wait_n(4);
    check("int_nested", {15'h0000, int_out}, 16'h0000);
    host.write_word(ctl_base, 8'h68);
    wait_n(3);
    check("smm_on", {15'h0000, int_out}, 16'h0001);
    host.write_word(ctl_base, 8'h28);
    wait_n(3);
    check("smm_hold", {15'h0000, int_out}, 16'h0001);
    host.write_word(ctl_base, 8'h48);
    wait_n(3);
    check("smm_off", {15'h0000, int_out}, 16'h0000);
    set_req(8'h02);
    cmd_read(8'h40, 8'h02, "isr_nop");
    cmd_read(8'h61, 8'h00, "isr_spec");
    pulse_ack(3'h1);
    cmd_read(8'h20, 8'h00, "isr_nonspec");
    // Re-init selects the request register again.
    init(8'hBD, 8'h12, 8'h02, 8'h0E);
    host.read_word(ctl_base, rd_val);
    check("irr_default", {8'h00, rd_val}, 16'h0002);
    pulse_ack(3'h1);
    cmd_read(8'h0B, 8'h00, "isr_auto");
    // Rotation on automatic end makes level one lowest, so three beats one.
    host.write_word(ctl_base, 8'h80);
    set_req(8'h0A);
    pulse_ack(3'h1);
    check("auto_rot", {13'h0000, int_level}, 16'h0003);
    // Slave role at the slave offsets, nesting bit left clear, explicit end needed.
    ctl_base = SLAVE_OFFSET;
    init(8'hBD, 8'h12, 8'h01, 8'h0A);
    check("slave", {15'h0000, master_role}, 16'h0000);
    check("slave_id", {8'h00, cascade_word}, 16'h0001);
    pulse_ack(3'h1);
    check("nest_off", {15'h0000, int_out}, 16'h0000);
    cmd_read(8'h0B, 8'h02, "isr_slave");
    cmd_read(8'h20, 8'h00, "isr_slave_end");
    // Special nesting in the master lets an equal level through.
    ctl_base = MASTER_OFFSET;
    init(8'hBD, 8'h12, 8'h02, 8'h1C);
    pulse_ack(3'h1);
    check("nest_on", {15'h0000, int_out}, 16'h0001);
    // Edge mode needs a fresh transition after init.
    set_req(8'h08);
    init(8'h11, 8'h12, 8'h02, 8'h0C);
    wait_n(4);
    check("edge_stale", {15'h0000, int_out}, 16'h0000);
    set_req(8'h00);
    wait_n(2);
    set_req(8'h08);
    wait_n(4);
    check("edge_new", {15'h0000, int_out}, 16'h0001);
    // Poll returns the best pending level and beats a read command in the same word.
    cmd_read(8'h0C, 8'h83, "poll");
    cmd_read(8'h0F, 8'h83, "poll_rr");
    host.read_word(ctl_base, rd_val);
    check("poll_rr_kept", {8'h00, rd_val}, 16'h0008);
    print_verdict();
  end
endmodule
`default_nettype wire
